// ===== msc_params.svh
// Constants of the muting sequence controller: offsets, reset values, timing
`ifndef MSC_PARAMS_SVH
`define MSC_PARAMS_SVH

// ****************************************************************
// Register map (APB byte addresses)
// ****************************************************************
`define MSC_ADDR_W          8
`define MSC_OFF_CTRL        8'h00
`define MSC_OFF_SENS_TIME   8'h04
`define MSC_OFF_TIMEOUT     8'h08
`define MSC_OFF_BLIND       8'h0C
`define MSC_OFF_EOM         8'h10
`define MSC_OFF_STATUS      8'h14

// ****************************************************************
// Field layout and reset values
// ****************************************************************
`define MSC_TIME_W          20
`define MSC_RST_CTRL        32'h00000000
`define MSC_RST_SENS_TIME   20'h007D0
`define MSC_RST_TIMEOUT     20'h02710
`define MSC_RST_BLIND       20'h000FA
`define MSC_RST_EOM         20'h009C4
`define MSC_UNLIMITED       20'h00000
`define MSC_STAT_ABORT_LSB  8
`define MSC_STAT_ABORT_MSB  10

// ****************************************************************
// Timing
// ****************************************************************
`define MSC_CLK_HZ          10000000
`define MSC_MS_PER_S        1000
`define MSC_MIN_SENS_MS     20'h00096

`endif

// ===== msc_pkg.sv
// Types shared by the muting sequence controller files
package msc_pkg;

  typedef enum logic [1:0] {msc_mode_concurrent, msc_mode_l_type, msc_mode_sequential} msc_mode_e;

  typedef enum logic [1:0] {both_directions_setting, msc_dir_up, msc_dir_down} msc_dir_e;

  typedef enum logic [2:0] {
    st_idle, st_ready, st_pair, st_seq, st_muted, st_release, st_blind
  } msc_state_e;

  typedef struct packed {
    logic [22:0] rsvd;
    logic        blind_en;
    logic        min_sensor_en;
    logic        enable_only;
    logic        with_enable;
    logic        close_sensor;
    msc_dir_e    dir;
    msc_mode_e   mode;
  } msc_ctrl_s;

  typedef struct packed {
    logic exit_sensor_b;
    logic exit_sensor_a;
    logic entry_sensor_b;
    logic entry_sensor_a;
  } msc_sensors_s;

endpackage

// ===== msc_ms_timer.sv
// Millisecond elapsed-time counter, saturating, cleared on demand
`timescale 1ns/1ps
module msc_ms_timer #(
  parameter int W = 20
) (
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire logic         tick_ms,
  input  wire logic         clear,
  output logic [W-1:0]      count_ms
);

  // Saturates so an unlimited wait never wraps back into range
  always_ff @(posedge core_clk) begin
    if (reset || clear) begin
      count_ms <= '0;
    end else if (tick_ms && (count_ms != {W{1'b1}})) begin
      count_ms <= count_ms + W'(1);
    end
  end

endmodule

// ===== msc_controller.sv
// Muting sequence controller: APB registers, sequence FSM, timers
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "msc_params.svh"
module msc_controller #(
  parameter int TICKS_PER_MS = `MSC_CLK_HZ / `MSC_MS_PER_S
) (
  input  wire logic                         core_clk,
  input  wire logic                         reset,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [`MSC_ADDR_W-1:0]       paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire msc_pkg::msc_sensors_s        sensors,
  input  wire logic                         curtain_in,
  input  wire logic                         enable_in,
  output logic                              muted_out,
  output logic                              curtain_eff_out
);

  localparam int PW = (TICKS_PER_MS > 1) ? $clog2(TICKS_PER_MS) : 1;
  localparam int TW = `MSC_TIME_W;

  // ****************************************************************
  // Register file
  // ****************************************************************
  msc_pkg::msc_ctrl_s   ctrl_reg;
  logic [TW-1:0]        sens_time_reg;
  logic [TW-1:0]        timeout_reg;
  logic [TW-1:0]        blind_reg;
  logic [TW-1:0]        eom_reg;
  logic [2:0]           abort_reg;
  logic [2:0]           abort_set;
  msc_pkg::msc_state_e  state_reg;
  msc_pkg::msc_state_e  state_next;
  logic                 dir_down_reg;
  logic                 dir_down_next;
  logic [2:0]           step_reg;
  logic [2:0]           step_next;
  logic                 armed_reg;
  logic                 en_prev_reg;
  logic                 broke_reg;
  logic                 start;
  logic [31:0]          rdata;
  logic [2:0]           sel;
  logic                 wr_fire;
  msc_pkg::msc_ctrl_s   wr_ctrl;

  function automatic logic [2:0] reg_sel(input logic [`MSC_ADDR_W-1:0] a);
    case (a)
      `MSC_OFF_CTRL:      reg_sel = 3'h1;
      `MSC_OFF_SENS_TIME: reg_sel = 3'h2;
      `MSC_OFF_TIMEOUT:   reg_sel = 3'h3;
      `MSC_OFF_BLIND:     reg_sel = 3'h4;
      `MSC_OFF_EOM:       reg_sel = 3'h5;
      `MSC_OFF_STATUS:    reg_sel = 3'h6;
      default:            reg_sel = 3'h0;
    endcase
  endfunction

  assign sel     = reg_sel(paddr);
  assign wr_fire = psel && penable && pready && pwrite;
  assign wr_ctrl = msc_pkg::msc_ctrl_s'(pwdata);

  always_comb begin
    case (sel)
      3'h1:    rdata = ctrl_reg;
      3'h2:    rdata = {{(32-TW){1'b0}}, sens_time_reg};
      3'h3:    rdata = {{(32-TW){1'b0}}, timeout_reg};
      3'h4:    rdata = {{(32-TW){1'b0}}, blind_reg};
      3'h5:    rdata = {{(32-TW){1'b0}}, eom_reg};
      3'h6:    rdata = {21'h000000, abort_reg, 1'b0, broke_reg, state_reg, dir_down_reg, armed_reg, muted_out};
      default: rdata = 32'h00000000;
    endcase
  end

  // Zero-wait slave: answer raised in the setup cycle, seen in first access cycle
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel && !penable && !pready;
      pslverr <= psel && !penable && !pready && (sel == 3'h0);
      prdata  <= (psel && !penable && !pready && !pwrite) ? rdata : 32'h00000000;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl_reg      <= msc_pkg::msc_ctrl_s'(`MSC_RST_CTRL);
      sens_time_reg <= `MSC_RST_SENS_TIME;
      timeout_reg   <= `MSC_RST_TIMEOUT;
      blind_reg     <= `MSC_RST_BLIND;
      eom_reg       <= `MSC_RST_EOM;
    end else if (wr_fire) begin
      case (sel)
        3'h1:    ctrl_reg      <= msc_pkg::msc_ctrl_s'({23'h000000, pwdata[8:0]});
        3'h2:    sens_time_reg <= pwdata[TW-1:0];
        3'h3:    timeout_reg   <= pwdata[TW-1:0];
        3'h4:    blind_reg     <= pwdata[TW-1:0];
        3'h5:    eom_reg       <= pwdata[TW-1:0];
        default: ;
      endcase
    end
  end

  // Sticky abort causes; a new abort in the clearing cycle survives
  always_ff @(posedge core_clk) begin
    if (reset) begin
      abort_reg <= 3'h0;
    end else if (wr_fire && (sel == 3'h6)) begin
      abort_reg <= (abort_reg & ~pwdata[`MSC_STAT_ABORT_MSB:`MSC_STAT_ABORT_LSB]) | abort_set;
    end else begin
      abort_reg <= abort_reg | abort_set;
    end
  end

  // ****************************************************************
  // Millisecond tick and timers
  // ****************************************************************
  logic [PW-1:0] presc_reg;
  logic          tick_reg;
  logic [TW-1:0] ph_ms;
  logic [TW-1:0] cyc_ms;
  logic          ph_clear;
  logic          cyc_clear;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      presc_reg <= '0;
      tick_reg  <= 1'b0;
    end else if (presc_reg == PW'(TICKS_PER_MS - 1)) begin
      presc_reg <= '0;
      tick_reg  <= 1'b1;
    end else begin
      presc_reg <= presc_reg + PW'(1);
      tick_reg  <= 1'b0;
    end
  end

  assign ph_clear  = (state_next != state_reg);
  assign cyc_clear = (state_reg == msc_pkg::st_idle) || (state_reg == msc_pkg::st_ready)
                     || (state_reg == msc_pkg::st_blind);

  msc_ms_timer #(.W(TW)) u_phase_timer (
    .core_clk (core_clk),
    .reset    (reset),
    .tick_ms  (tick_reg),
    .clear    (ph_clear),
    .count_ms (ph_ms)
  );

  msc_ms_timer #(.W(TW)) u_cycle_timer (
    .core_clk (core_clk),
    .reset    (reset),
    .tick_ms  (tick_reg),
    .clear    (cyc_clear),
    .count_ms (cyc_ms)
  );

  // ****************************************************************
  // Enable handling
  // ****************************************************************
  logic en_rise;
  logic en_fall;
  logic cancel;
  logic l_mode;
  logic seq_mode;

  assign en_rise  = enable_in && !en_prev_reg;
  assign en_fall  = !enable_in && en_prev_reg;
  assign cancel   = ctrl_reg.with_enable && !ctrl_reg.enable_only && en_fall;
  assign l_mode   = (ctrl_reg.mode == msc_pkg::msc_mode_l_type);
  assign seq_mode = (ctrl_reg.mode == msc_pkg::msc_mode_sequential);

  // Starts high so an enable already high out of reset is not a rising edge
  always_ff @(posedge core_clk) begin
    if (reset) begin
      en_prev_reg <= 1'b1;
    end else begin
      en_prev_reg <= enable_in;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      armed_reg <= 1'b0;
    end else if (wr_fire && (sel == 3'h1)) begin
      // Stale arming from always-enabled use must not leak into enable mode
      armed_reg <= !wr_ctrl.with_enable;
    end else if (!ctrl_reg.with_enable) begin
      armed_reg <= 1'b1;
    end else if (en_rise) begin
      armed_reg <= 1'b1;
    end else if (start || cancel) begin
      armed_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Sequence state machine
  // ****************************************************************
  logic [3:0] ord;
  logic       entry_any;
  logic       exit_any;
  logic       precond;
  logic       in_cycle;
  logic       tout_hit;
  logic       closed;
  logic       over_step;

  function automatic logic [3:0] ordered(input msc_pkg::msc_sensors_s s, input logic down);
    ordered = down ? {s.entry_sensor_a, s.entry_sensor_b, s.exit_sensor_a, s.exit_sensor_b}
                   : {s.exit_sensor_b, s.exit_sensor_a, s.entry_sensor_b, s.entry_sensor_a};
  endfunction

  assign ord       = ordered(sensors, dir_down_reg);
  assign entry_any = sensors.entry_sensor_a || sensors.entry_sensor_b;
  assign exit_any  = !l_mode && (sensors.exit_sensor_a || sensors.exit_sensor_b);
  assign precond   = curtain_in && !entry_any && !exit_any;
  assign in_cycle  = (state_reg == msc_pkg::st_pair) || (state_reg == msc_pkg::st_seq)
                     || (state_reg == msc_pkg::st_muted) || (state_reg == msc_pkg::st_release);
  assign tout_hit  = (timeout_reg != `MSC_UNLIMITED) && (cyc_ms >= timeout_reg);

  always_comb begin
    over_step = 1'b0;
    for (int k = 1; k < 4; k++) begin
      if ((3'(k) > step_reg) && ord[k]) begin
        over_step = 1'b1;
      end
    end
  end

  always_comb begin
    state_next    = state_reg;
    dir_down_next = dir_down_reg;
    step_next     = step_reg;
    abort_set     = 3'h0;
    start         = 1'b0;
    closed        = 1'b0;
    case (state_reg)
      msc_pkg::st_idle: begin
        if (precond) begin
          state_next = msc_pkg::st_ready;
        end
      end
      msc_pkg::st_ready: begin
        if (!curtain_in) begin
          state_next = msc_pkg::st_idle;
        end else if (entry_any) begin
          if (armed_reg && (ctrl_reg.dir != msc_pkg::msc_dir_down)) begin
            start         = 1'b1;
            dir_down_next = 1'b0;
            step_next     = 3'h1;
            state_next    = seq_mode ? msc_pkg::st_seq : msc_pkg::st_pair;
          end else begin
            state_next = msc_pkg::st_idle;
          end
        end else if (exit_any) begin
          if (armed_reg && (ctrl_reg.dir != msc_pkg::msc_dir_up)) begin
            start         = 1'b1;
            dir_down_next = 1'b1;
            step_next     = 3'h1;
            state_next    = seq_mode ? msc_pkg::st_seq : msc_pkg::st_pair;
          end else begin
            state_next = msc_pkg::st_idle;
          end
        end
      end
      msc_pkg::st_pair: begin
        if (ord[0] && ord[1] && (ph_ms <= sens_time_reg)) begin
          if (ctrl_reg.min_sensor_en && (ph_ms <= `MSC_MIN_SENS_MS)) begin
            state_next   = msc_pkg::st_idle;
            abort_set[1] = 1'b1;
          end else begin
            state_next = msc_pkg::st_muted;
          end
        end else if ((ph_ms > sens_time_reg) || !(ord[0] || ord[1]) || (!l_mode && (ord[2] || ord[3]))
                     || !curtain_in) begin
          state_next   = msc_pkg::st_idle;
          abort_set[1] = 1'b1;
        end
      end
      msc_pkg::st_seq: begin
        // No time limit between steps beyond the cycle timeout; order and curtain decide each step
        if (over_step || !curtain_in) begin
          state_next   = msc_pkg::st_idle;
          abort_set[1] = 1'b1;
        end else if (ord[step_reg[1:0]]) begin
          step_next = step_reg + 3'h1;
          if (step_reg == 3'h3) begin
            state_next = msc_pkg::st_muted;
          end
        end
      end
      msc_pkg::st_muted: begin
        if (l_mode) begin
          if (!ord[0] || !ord[1]) begin
            state_next = msc_pkg::st_release;
          end
        end else if (ctrl_reg.close_sensor) begin
          closed = !ord[0] && !ord[1] && !ord[2];
        end else begin
          closed = broke_reg && curtain_in;
        end
      end
      msc_pkg::st_release: begin
        closed = (ph_ms >= eom_reg) || (curtain_in && !entry_any);
      end
      msc_pkg::st_blind: begin
        if (ph_ms >= blind_reg) begin
          state_next = msc_pkg::st_idle;
        end
      end
      default: state_next = msc_pkg::st_idle;
    endcase
    if (closed) begin
      // Blind time only follows a curtain close, except in L mode
      if (ctrl_reg.blind_en && (l_mode || !ctrl_reg.close_sensor)) begin
        state_next = msc_pkg::st_blind;
      end else begin
        state_next = msc_pkg::st_idle;
      end
    end
    if (in_cycle && tout_hit) begin
      state_next   = msc_pkg::st_idle;
      abort_set[0] = 1'b1;
    end
    if (cancel && (state_reg != msc_pkg::st_idle)) begin
      state_next   = msc_pkg::st_idle;
      abort_set[2] = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_reg    <= msc_pkg::st_idle;
      dir_down_reg <= 1'b0;
      step_reg     <= 3'h0;
    end else begin
      state_reg    <= state_next;
      dir_down_reg <= dir_down_next;
      step_reg     <= step_next;
    end
  end

  // Remembers that material actually broke the curtain during muting
  always_ff @(posedge core_clk) begin
    if (reset || (state_reg != msc_pkg::st_muted)) begin
      broke_reg <= 1'b0;
    end else if (!curtain_in) begin
      broke_reg <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      muted_out       <= 1'b0;
      curtain_eff_out <= 1'b0;
    end else begin
      muted_out       <= (state_next == msc_pkg::st_muted) || (state_next == msc_pkg::st_release);
      curtain_eff_out <= curtain_in || (state_next == msc_pkg::st_muted)
                         || (state_next == msc_pkg::st_release) || (state_next == msc_pkg::st_blind);
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_cycle_start;
    (state_reg == msc_pkg::st_ready) && start;
  endsequence

  sequence s_muting_begins;
    (state_reg == msc_pkg::st_pair) && (state_next == msc_pkg::st_muted);
  endsequence

  property p_start_preconditions;
    @(posedge core_clk) disable iff (reset)
      (state_reg == msc_pkg::st_idle) ##1 (state_reg == msc_pkg::st_ready) |-> $past(precond);
  endproperty
  a_start_preconditions: assert property (p_start_preconditions) else $error("ready without clear opening");

  property p_timeout_abort;
    @(posedge core_clk) disable iff (reset)
      (in_cycle && tout_hit && !closed) |=> !muted_out && (state_reg == msc_pkg::st_idle) && abort_reg[0];
  endproperty
  a_timeout_abort: assert property (p_timeout_abort) else $error("timeout did not abort muting");

  property p_always_armed;
    @(posedge core_clk) disable iff (reset)
      !ctrl_reg.with_enable ##1 !ctrl_reg.with_enable |-> armed_reg;
  endproperty
  a_always_armed: assert property (p_always_armed) else $error("not armed without enable option");

  property p_start_needs_arm;
    @(posedge core_clk) disable iff (reset)
      s_cycle_start |-> armed_reg ##1 (!ctrl_reg.with_enable || !armed_reg || $past(en_rise));
  endproperty
  a_start_needs_arm: assert property (p_start_needs_arm) else $error("cycle started without arming");

  property p_fall_cancels;
    @(posedge core_clk) disable iff (reset)
      (cancel && in_cycle) |=> (state_reg == msc_pkg::st_idle) && !muted_out ##1 !muted_out;
  endproperty
  a_fall_cancels: assert property (p_fall_cancels) else $error("falling enable did not cancel");

  property p_direction;
    @(posedge core_clk) disable iff (reset)
      s_cycle_start |=> (dir_down_reg == (ctrl_reg.dir == msc_pkg::msc_dir_down)) ||
                        (ctrl_reg.dir == msc_pkg::both_directions_setting);
  endproperty
  a_direction: assert property (p_direction) else $error("cycle started against direction");

  property p_sensor_window;
    @(posedge core_clk) disable iff (reset)
      s_muting_begins |-> (ph_ms <= sens_time_reg) ##1 muted_out;
  endproperty
  a_sensor_window: assert property (p_sensor_window) else $error("muting outside sensor time");

  property p_min_time;
    @(posedge core_clk) disable iff (reset)
      s_muting_begins ##0 ctrl_reg.min_sensor_en |-> (ph_ms > `MSC_MIN_SENS_MS);
  endproperty
  a_min_time: assert property (p_min_time) else $error("pair closer than minimum sensor time");

  property p_blind_holds;
    @(posedge core_clk) disable iff (reset)
      (state_reg == msc_pkg::st_blind) && (state_next == msc_pkg::st_blind) |=> curtain_eff_out && !muted_out;
  endproperty
  a_blind_holds: assert property (p_blind_holds) else $error("curtain not held during blind time");

endmodule

// ===== msc_field_model.sv
// Model of the field side: muting sensors, protected curtain and enable line
`timescale 1ns/1ps
module msc_field_model (
  input  wire logic             core_clk,
  output msc_pkg::msc_sensors_s sensors,
  output logic                  curtain_in,
  output logic                  enable_in
);
  initial begin
    sensors    = '0;
    curtain_in = 1'b1;
    enable_in  = 1'b0;
  end
  // Levels change just after an edge so the core never samples them mid-change
  task automatic put(input logic [3:0] s, input logic c, input logic e);
    @(posedge core_clk);
    sensors    <= msc_pkg::msc_sensors_s'(s);
    curtain_in <= c;
    enable_in  <= e;
  endtask
endmodule

// ===== muting_sequence_controller_tb.sv
// Self-checking testbench of the muting sequence controller
`timescale 1ns/1ps
`include "msc_params.svh"
module muting_sequence_controller_tb;
  logic                   core_clk;
  logic                   reset   = 1'b1;
  logic                   psel    = 1'b0;
  logic                   penable = 1'b0;
  logic                   pwrite  = 1'b0;
  logic [`MSC_ADDR_W-1:0] paddr   = '0;
  logic [31:0]            pwdata  = '0;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  msc_pkg::msc_sensors_s  sensors;
  logic                   curtain_in;
  logic                   enable_in;
  logic                   muted_out;
  logic                   curtain_eff_out;
  logic [31:0]            rd;
  logic                   err;
  int                     num_errors = 0;
  int                     checks     = 0;
  logic [7:0]             offs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
  // Status after reset: always armed, waiting in ready with the opening clear
  logic [31:0]            rstv [6] = '{32'h0, 32'h7D0, 32'h2710, 32'hFA, 32'h9C4, 32'hA};

  // One ms is ten cycles, so every window is short enough to simulate
  msc_controller #(.TICKS_PER_MS(10)) i_msc_controller (
    .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sensors(sensors), .curtain_in(curtain_in), .enable_in(enable_in),
    .muted_out(muted_out), .curtain_eff_out(curtain_eff_out)
  );

  msc_field_model i_msc_field_model (
    .core_clk(core_clk), .sensors(sensors), .curtain_in(curtain_in), .enable_in(enable_in)
  );

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic close_out();
    if (num_errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      close_out();
    end
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // First nibble is the idle level, then four sensor steps 3 ms apart
  task automatic run(input logic [31:0] ctrl, input logic [19:0] seq, input logic en, input logic exp);
    apb(1'b1, `MSC_OFF_CTRL, ctrl);
    i_msc_field_model.put(seq[19:16], 1'b1, en);
    wt(30);
    for (int i = 3; i >= 0; i--) begin
      i_msc_field_model.put(seq[4*i +: 4], 1'b1, en);
      wt(30);
    end
    chk(muted_out, exp);
  endtask

  // Curtain drop and rise closes any cycle; enable goes low before the next arming
  task automatic clear();
    i_msc_field_model.put(4'h0, 1'b0, 1'b0);
    wt(5);
    i_msc_field_model.put(4'h0, 1'b1, 1'b0);
    wt(5);
    chk(muted_out, 1'b0);
    wt(60);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    wt(8);
    reset <= 1'b0;
    wt(2);
    foreach (offs[i]) begin
      apb(1'b0, offs[i], 32'h0);
      chk(rd, rstv[i]);
    end
    apb(1'b0, 8'h18, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, `MSC_OFF_SENS_TIME, 32'h14);
    apb(1'b1, `MSC_OFF_TIMEOUT, 32'h64);
    apb(1'b1, `MSC_OFF_BLIND, 32'h5);
    apb(1'b1, `MSC_OFF_EOM, 32'hA);
    apb(1'b0, `MSC_OFF_SENS_TIME, 32'h0);
    chk(rd, 32'h14);
    run(32'h0, 20'h01333, 1'b0, 1'b1);
    clear();
    run(32'h0, 20'h08CCC, 1'b0, 1'b1);
    clear();
    i_msc_field_model.put(4'h1, 1'b0, 1'b0);
    wt(5);
    run(32'h0, 20'h11333, 1'b0, 1'b0);
    clear();
    run(32'h8, 20'h01333, 1'b0, 1'b0);
    clear();
    run(32'h4, 20'h08CCC, 1'b0, 1'b0);
    clear();
    run(32'h80, 20'h01333, 1'b0, 1'b0);
    clear();
    run(32'h2, 20'h0137F, 1'b0, 1'b1);
    clear();
    run(32'h2, 20'h08CEF, 1'b0, 1'b1);
    clear();
    run(32'h1, 20'h89BBB, 1'b0, 1'b1);
    clear();
    run(32'h20, 20'h01333, 1'b0, 1'b0);
    clear();
    run(32'h20, 20'h01333, 1'b1, 1'b1);
    i_msc_field_model.put(4'h3, 1'b1, 1'b0);
    wt(3);
    chk(muted_out, 1'b0);
    clear();
    run(32'h60, 20'h01333, 1'b1, 1'b1);
    i_msc_field_model.put(4'h3, 1'b1, 1'b0);
    wt(3);
    chk(muted_out, 1'b1);
    clear();
    run(32'h10, 20'h013FF, 1'b0, 1'b1);
    i_msc_field_model.put(4'hF, 1'b0, 1'b0);
    wt(5);
    i_msc_field_model.put(4'hF, 1'b1, 1'b0);
    wt(5);
    chk(muted_out, 1'b1);
    i_msc_field_model.put(4'h8, 1'b1, 1'b0);
    wt(5);
    chk(muted_out, 1'b0);
    clear();
    run(32'h100, 20'h01333, 1'b0, 1'b1);
    i_msc_field_model.put(4'h3, 1'b0, 1'b0);
    wt(5);
    i_msc_field_model.put(4'h0, 1'b1, 1'b0);
    wt(4);
    chk(muted_out, 1'b0);
    i_msc_field_model.put(4'h0, 1'b0, 1'b0);
    wt(15);
    chk(curtain_eff_out, 1'b1);
    wt(60);
    chk(curtain_eff_out, 1'b0);
    clear();
    run(32'h1, 20'h01333, 1'b0, 1'b1);
    i_msc_field_model.put(4'h2, 1'b0, 1'b0);
    wt(50);
    chk(muted_out, 1'b1);
    wt(80);
    chk(muted_out, 1'b0);
    clear();
    run(32'h0, 20'h01333, 1'b0, 1'b1);
    wt(600);
    chk(muted_out, 1'b1);
    wt(500);
    chk(muted_out, 1'b0);
    clear();
    close_out();
  end
endmodule
